// *** dss_sequencer.sv ***
// dual slot sample sequencer: registers, sample clock, trigger and slots
// assumes a register port already decoded from the serial host link
//
// Function
// - slot A then slot B each period
// - each slot has its own settings
// - slot A time: delay plus count times spacing
// - slot B time: delay plus count times spacing
// - low byte sets delay to first pulse
// - low byte sets spacing between pulses
// - compute 68 us after A, 20 after B
// - sleep at least 222 us between periods
// - slot B input routing field decode
// - slot A input routing, same decode
// - rate register paces periods on slow clock
// - trigger pin select field
// - pin input buffer enables
// - trigger enable replaces internal sample timer
// - trigger waits one to two slow cycles
// - enable plus bypass selects external slow clock
// - mode field, standby after reset
module dss_sequencer (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        reg_wr_en_in,
  input  wire logic        reg_rd_en_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  output logic             reg_rdata_valid_out,
  input  wire logic        irq_pin_in,
  output logic             irq_pin_out,
  output logic             irq_pin_oe_n_out,
  input  wire logic        pd_pin_in,
  output logic             pd_pin_out,
  output logic             pd_pin_oe_n_out,
  output logic             slot_a_pulse_out,
  output logic             slot_b_pulse_out,
  output logic             slot_a_active_out,
  output logic             slot_b_active_out,
  output logic             sensor_lo_connect_out,
  output logic             sensor_hi_connect_out,
  output logic      [2:0]  seq_state_out
);

  `include "dss_params.svh"

  // ****************************************************************
  // state and wires
  // ****************************************************************
  dss_pkg::dss_top_st_t s;
  dss_pkg::dss_top_st_t next_s;

  logic [1:0] pin_sync;
  logic       a_busy;
  logic       a_pulse;
  logic       a_done;
  logic       b_busy;
  logic       b_pulse;
  logic       b_done;
  logic       abort;
  logic       a_en;
  logic       b_en;

  // a slot with zero pulses is treated as unused
  assign a_en  = (s.a_spacing[15:8] != 8'h00);
  assign b_en  = (s.b_spacing[15:8] != 8'h00);
  assign abort = (s.mode[1:0] != `DSS_MODE_NORMAL);

  // ****************************************************************
  // pin synchroniser and slot timers
  // ****************************************************************
  dss_sync2 u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({pd_pin_in, irq_pin_in}),
    .sync_out   (pin_sync)
  );

  // each timer reads only its own slot's registers
  dss_slot_timer u_slot_a (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .us_tick_in    (s.us_tick),
    .start_in      (s.start_a),
    .abort_in      (abort),
    .delay_us_in   (s.a_delay[7:0]),
    .spacing_us_in (s.a_spacing[7:0]),
    .count_in      (s.a_spacing[15:8]),
    .busy_out      (a_busy),
    .pulse_out     (a_pulse),
    .done_out      (a_done)
  );

  dss_slot_timer u_slot_b (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .us_tick_in    (s.us_tick),
    .start_in      (s.start_b),
    .abort_in      (abort),
    .delay_us_in   (s.b_delay[7:0]),
    .spacing_us_in (s.b_spacing[7:0]),
    .count_in      (s.b_spacing[15:8]),
    .busy_out      (b_busy),
    .pulse_out     (b_pulse),
    .done_out      (b_done)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic       irq_in;
    logic       pd_in;
    logic       trig_lvl;
    logic       slow_edge;
    logic       ext_clk;
    logic       start_req;
    logic       consume;
    logic [9:0] slow_top;
    logic [15:0] rate_top;
    logic [3:0] route;
    irq_in    = 1'b0;
    pd_in     = 1'b0;
    trig_lvl  = 1'b0;
    slow_edge = 1'b0;
    ext_clk   = 1'b0;
    start_req = 1'b0;
    consume   = 1'b0;
    slow_top  = 10'h000;
    rate_top  = 16'h0000;
    route     = 4'h0;
    next_s    = s;

    // register writes, read data one cycle after the strobe
    next_s.rdata_valid = reg_rd_en_in;
    if (reg_rd_en_in) begin
      unique case (reg_addr_in)
        `DSS_OFF_MODE:      next_s.rdata = s.mode;
        `DSS_OFF_RATE:      next_s.rdata = s.rate;
        `DSS_OFF_ROUTE:     next_s.rdata = s.route;
        `DSS_OFF_A_DELAY:   next_s.rdata = s.a_delay;
        `DSS_OFF_A_SPACING: next_s.rdata = s.a_spacing;
        `DSS_OFF_B_DELAY:   next_s.rdata = s.b_delay;
        `DSS_OFF_B_SPACING: next_s.rdata = s.b_spacing;
        `DSS_OFF_EXT_TRIG:  next_s.rdata = s.ext_trig;
        `DSS_OFF_CLOCK:     next_s.rdata = s.clock;
        `DSS_OFF_PIN_SEL:   next_s.rdata = s.pin_sel;
        default:            next_s.rdata = 16'h0000;
      endcase
    end
    if (reg_wr_en_in) begin
      unique case (reg_addr_in)
        `DSS_OFF_MODE:      next_s.mode      = reg_wdata_in;
        `DSS_OFF_RATE:      next_s.rate      = reg_wdata_in;
        `DSS_OFF_ROUTE:     next_s.route     = reg_wdata_in;
        `DSS_OFF_A_DELAY:   next_s.a_delay   = reg_wdata_in;
        `DSS_OFF_A_SPACING: next_s.a_spacing = reg_wdata_in;
        `DSS_OFF_B_DELAY:   next_s.b_delay   = reg_wdata_in;
        `DSS_OFF_B_SPACING: next_s.b_spacing = reg_wdata_in;
        `DSS_OFF_EXT_TRIG:  next_s.ext_trig  = reg_wdata_in;
        `DSS_OFF_CLOCK:     next_s.clock     = reg_wdata_in;
        `DSS_OFF_PIN_SEL:   next_s.pin_sel   = reg_wdata_in;
        default:            next_s.mode      = s.mode;
      endcase
    end

    // pins count only while their input buffer is on
    irq_in = pin_sync[0] & s.pin_sel[`DSS_IRQ_BUF_BIT];
    pd_in  = pin_sync[1] & s.pin_sel[`DSS_PD_BUF_BIT];

    // microsecond strobe
    next_s.us_tick = 1'b0;
    if (s.us_div >= 5'(`DSS_US_CYCLES - 1)) begin
      next_s.us_div  = 5'h00;
      next_s.us_tick = 1'b1;
    end else begin
      next_s.us_div = s.us_div + 5'h01;
    end

    // slow clock: trimmed divider, or edges of the external clock
    ext_clk        = s.clock[`DSS_CLK_EN_BIT] & s.clock[`DSS_CLK_BYP_BIT];
    next_s.pd_prev = pd_in;
    slow_edge      = pd_in & ~s.pd_prev;
    slow_top = 10'(`DSS_SLOW_BASE_CYCLES - `DSS_TRIM_CENTER - 1)
             + {4'h0, s.clock[`DSS_TRIM_LSB +: 6]};
    if (s.slow_div >= slow_top) begin
      next_s.slow_div = 10'h000;
    end else begin
      next_s.slow_div = s.slow_div + 10'h001;
    end
    if (ext_clk) begin
      next_s.slow_tick = slow_edge;
    end else begin
      next_s.slow_tick = (s.slow_div >= slow_top);
    end

    // trigger pin selection and edge detect on the synced level
    unique case (s.pin_sel[`DSS_TRIG_SEL_LSB +: 2])
      `DSS_TRIG_SEL_IRQ: trig_lvl = irq_in;
      `DSS_TRIG_SEL_PD:  trig_lvl = pd_in;
      default:           trig_lvl = 1'b0;
    endcase
    next_s.trig_prev = trig_lvl;

    // period start: internal rate timer or delayed trigger edge
    rate_top = (s.rate == 16'h0000) ? 16'h0000 : s.rate - 16'h0001;
    if (abort) begin
      next_s.rate_cnt = 16'h0000;
      next_s.ext_wait = 2'h0;
    end else if (s.ext_trig[`DSS_EXT_TRIG_BIT]) begin
      next_s.rate_cnt = 16'h0000;
      if (trig_lvl && !s.trig_prev) begin
        next_s.ext_wait = 2'(`DSS_EXT_WAIT_TICKS);
      end else if (s.slow_tick && s.ext_wait != 2'h0) begin
        next_s.ext_wait = s.ext_wait - 2'h1;
        start_req       = (s.ext_wait == 2'h1);
      end
    end else if (s.slow_tick) begin
      if (s.rate_cnt >= rate_top) begin
        next_s.rate_cnt = 16'h0000;
        start_req       = 1'b1;
      end else begin
        next_s.rate_cnt = s.rate_cnt + 16'h0001;
      end
    end

    // slot sequence
    next_s.start_a = 1'b0;
    next_s.start_b = 1'b0;
    if (abort) begin
      next_s.state = dss_pkg::DSS_STANDBY;
    end else begin
      unique case (s.state)
        dss_pkg::DSS_STANDBY: next_s.state = dss_pkg::DSS_WAIT;
        dss_pkg::DSS_WAIT: begin
          if (s.start_pend) begin
            consume = 1'b1;
            if (a_en) begin
              next_s.state   = dss_pkg::DSS_SLOT_A;
              next_s.start_a = 1'b1;
            end else if (b_en) begin
              next_s.state   = dss_pkg::DSS_SLOT_B;
              next_s.start_b = 1'b1;
            end
          end
        end
        dss_pkg::DSS_SLOT_A: begin
          if (a_done) begin
            next_s.state   = dss_pkg::DSS_COMP_A;
            next_s.seq_cnt = 8'(`DSS_COMPUTE_A_US);
          end
        end
        dss_pkg::DSS_COMP_A: begin
          if (s.us_tick) begin
            if (s.seq_cnt <= 8'h01) begin
              if (b_en) begin
                next_s.state   = dss_pkg::DSS_SLOT_B;
                next_s.start_b = 1'b1;
              end else begin
                next_s.state   = dss_pkg::DSS_SLEEP;
                next_s.seq_cnt = 8'(`DSS_SLEEP_MIN_US);
              end
            end else begin
              next_s.seq_cnt = s.seq_cnt - 8'h01;
            end
          end
        end
        dss_pkg::DSS_SLOT_B: begin
          if (b_done) begin
            next_s.state   = dss_pkg::DSS_COMP_B;
            next_s.seq_cnt = 8'(`DSS_COMPUTE_B_US);
          end
        end
        dss_pkg::DSS_COMP_B: begin
          if (s.us_tick) begin
            if (s.seq_cnt <= 8'h01) begin
              next_s.state   = dss_pkg::DSS_SLEEP;
              next_s.seq_cnt = 8'(`DSS_SLEEP_MIN_US);
            end else begin
              next_s.seq_cnt = s.seq_cnt - 8'h01;
            end
          end
        end
        dss_pkg::DSS_SLEEP: begin
          if (s.us_tick) begin
            if (s.seq_cnt <= 8'h01) begin
              next_s.state = dss_pkg::DSS_WAIT;
            end else begin
              next_s.seq_cnt = s.seq_cnt - 8'h01;
            end
          end
        end
        default: next_s.state = dss_pkg::DSS_STANDBY;
      endcase
    end

    // a start seen while one is consumed is kept, set wins
    next_s.start_pend = (s.start_pend & ~consume & ~abort) | start_req;

    // sensor routing for the slot being entered or held
    if (next_s.state == dss_pkg::DSS_SLOT_A) begin
      route = s.route[`DSS_ROUTE_A_LSB +: 4];
    end else if (next_s.state == dss_pkg::DSS_SLOT_B) begin
      route = s.route[`DSS_ROUTE_B_LSB +: 4];
    end else begin
      route = `DSS_ROUTE_FLOAT;
    end
    next_s.conn_lo = (route == `DSS_ROUTE_ALL) || (route == `DSS_ROUTE_LO);
    next_s.conn_hi = (route == `DSS_ROUTE_ALL) || (route == `DSS_ROUTE_HI);

    // powerdown status is high while no slot or compute runs
    next_s.pd_status = (next_s.state == dss_pkg::DSS_STANDBY)
                    || (next_s.state == dss_pkg::DSS_WAIT)
                    || (next_s.state == dss_pkg::DSS_SLEEP);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s           <= '0;
      s.mode      <= `DSS_RST_MODE;
      s.rate      <= `DSS_RST_RATE;
      s.route     <= `DSS_RST_ZERO;
      s.a_delay   <= `DSS_RST_ZERO;
      s.a_spacing <= `DSS_RST_ZERO;
      s.b_delay   <= `DSS_RST_ZERO;
      s.b_spacing <= `DSS_RST_ZERO;
      s.ext_trig  <= `DSS_RST_ZERO;
      s.clock     <= `DSS_RST_CLOCK;
      s.pin_sel   <= `DSS_RST_ZERO;
      s.state     <= dss_pkg::DSS_STANDBY;
      s.pd_status <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // a pin whose input buffer is on is released, never driven
  assign irq_pin_out           = 1'b0;
  assign irq_pin_oe_n_out      = s.pin_sel[`DSS_IRQ_BUF_BIT];
  assign pd_pin_out            = s.pd_status;
  assign pd_pin_oe_n_out       = s.pin_sel[`DSS_PD_BUF_BIT];
  assign slot_a_pulse_out      = a_pulse;
  assign slot_b_pulse_out      = b_pulse;
  assign slot_a_active_out     = a_busy;
  assign slot_b_active_out     = b_busy;
  assign sensor_lo_connect_out = s.conn_lo;
  assign sensor_hi_connect_out = s.conn_hi;
  assign seq_state_out         = s.state;
  assign reg_rdata_out         = s.rdata;
  assign reg_rdata_valid_out   = s.rdata_valid;

endmodule // dss_sequencer

// *** dss_params.svh ***
// constants of the dual slot sample sequencer: offsets, fields, resets, times
// assumes a 20 MHz system clock and an 8-bit register address space
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH

// ****************************************************************
// clock and time base
// ****************************************************************
`define DSS_CLK_HZ            20000000
`define DSS_US_CYCLES         (`DSS_CLK_HZ / 1000000)
`define DSS_SLOW_HZ           32768
`define DSS_SLOW_BASE_CYCLES  (`DSS_CLK_HZ / `DSS_SLOW_HZ)
`define DSS_TRIM_CENTER       32
`define DSS_COMPUTE_A_US      68
`define DSS_COMPUTE_B_US      20
`define DSS_SLEEP_MIN_US      222
`define DSS_EXT_WAIT_TICKS    2

// ****************************************************************
// register offsets
// ****************************************************************
`define DSS_OFF_MODE          8'h10
`define DSS_OFF_RATE          8'h12
`define DSS_OFF_ROUTE         8'h14
`define DSS_OFF_A_DELAY       8'h30
`define DSS_OFF_A_SPACING     8'h31
`define DSS_OFF_B_DELAY       8'h35
`define DSS_OFF_B_SPACING     8'h36
`define DSS_OFF_EXT_TRIG      8'h38
`define DSS_OFF_CLOCK         8'h4b
`define DSS_OFF_PIN_SEL       8'h4f

// ****************************************************************
// field positions and codes
// ****************************************************************
`define DSS_MODE_LSB          0
`define DSS_MODE_STANDBY      2'h0
`define DSS_MODE_PROGRAM      2'h1
`define DSS_MODE_NORMAL       2'h2
`define DSS_ROUTE_A_LSB       4
`define DSS_ROUTE_B_LSB       8
`define DSS_ROUTE_FLOAT       4'h0
`define DSS_ROUTE_ALL         4'h1
`define DSS_ROUTE_HI          4'h4
`define DSS_ROUTE_LO          4'h5
`define DSS_COUNT_LSB         8
`define DSS_BYTE_LSB          0
`define DSS_EXT_TRIG_BIT      14
`define DSS_TRIM_LSB          0
`define DSS_CLK_EN_BIT        7
`define DSS_CLK_BYP_BIT       8
`define DSS_TRIG_SEL_LSB      2
`define DSS_TRIG_SEL_IRQ      2'h1
`define DSS_TRIG_SEL_PD       2'h2
`define DSS_IRQ_BUF_BIT       1
`define DSS_PD_BUF_BIT        5

// ****************************************************************
// reset values
// ****************************************************************
`define DSS_RST_MODE          16'h0000
`define DSS_RST_RATE          16'h0008
`define DSS_RST_ZERO          16'h0000
`define DSS_RST_CLOCK         16'h2612

`endif

// *** dss_pkg.sv ***
// types of the dual slot sample sequencer
// assumes dss_params.svh is compiled alongside
package dss_pkg;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    DSS_STANDBY = 3'b000,
    DSS_WAIT    = 3'b001,
    DSS_SLOT_A  = 3'b010,
    DSS_COMP_A  = 3'b011,
    DSS_SLOT_B  = 3'b100,
    DSS_COMP_B  = 3'b101,
    DSS_SLEEP   = 3'b110
  } dss_state_t;

  // ****************************************************************
  // module state records
  // ****************************************************************
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } dss_sync_st_t;

  typedef struct packed {
    logic       busy;
    logic       pulse;
    logic       done;
    logic [7:0] cnt;
    logic [7:0] left;
  } dss_slot_st_t;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] rate;
    logic [15:0] route;
    logic [15:0] a_delay;
    logic [15:0] a_spacing;
    logic [15:0] b_delay;
    logic [15:0] b_spacing;
    logic [15:0] ext_trig;
    logic [15:0] clock;
    logic [15:0] pin_sel;
    dss_state_t  state;
    logic [4:0]  us_div;
    logic        us_tick;
    logic [9:0]  slow_div;
    logic        slow_tick;
    logic [15:0] rate_cnt;
    logic        trig_prev;
    logic        pd_prev;
    logic [1:0]  ext_wait;
    logic        start_pend;
    logic [7:0]  seq_cnt;
    logic        start_a;
    logic        start_b;
    logic        conn_lo;
    logic        conn_hi;
    logic        pd_status;
    logic [15:0] rdata;
    logic        rdata_valid;
  } dss_top_st_t;

endpackage

// *** dss_sync2.sv ***
// two-stage synchroniser for the two sampled pins
// assumes the inputs are asynchronous to clk_sys_in
module dss_sync2 (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);

  dss_pkg::dss_sync_st_t s;
  dss_pkg::dss_sync_st_t next_s;

  // meta feeds only the second stage, nothing else looks at it
  always_comb begin
    next_s        = s;
    next_s.meta   = async_in;
    next_s.stable = s.meta;
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stable;

endmodule // dss_sync2

// *** dss_slot_timer.sv ***
// one time slot: pulse delay, then a train of pulses at a fixed spacing
// assumes us_tick_in is a one-cycle strobe once per microsecond
module dss_slot_timer (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       us_tick_in,
  input  wire logic       start_in,
  input  wire logic       abort_in,
  input  wire logic [7:0] delay_us_in,
  input  wire logic [7:0] spacing_us_in,
  input  wire logic [7:0] count_in,
  output logic            busy_out,
  output logic            pulse_out,
  output logic            done_out
);

  dss_pkg::dss_slot_st_t s;
  dss_pkg::dss_slot_st_t next_s;

  // active time is delay plus count times spacing, pulse one us wide
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (abort_in) begin
      next_s.busy  = 1'b0;
      next_s.pulse = 1'b0;
    end else if (start_in) begin
      next_s.busy  = 1'b1;
      next_s.pulse = 1'b0;
      next_s.cnt   = delay_us_in;
      next_s.left  = count_in;
    end else if (s.busy && us_tick_in) begin
      next_s.pulse = 1'b0;
      if (s.cnt <= 8'h01) begin
        if (s.left == 8'h00) begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end else begin
          next_s.pulse = 1'b1;
          next_s.left  = s.left - 8'h01;
          next_s.cnt   = spacing_us_in;
        end
      end else begin
        next_s.cnt = s.cnt - 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy_out  = s.busy;
  assign pulse_out = s.pulse;
  assign done_out  = s.done;

endmodule // dss_slot_timer

// *** dss_sequencer_sva.sv ***
// port checker of the dual slot sample sequencer
// assumes a bind onto dss_sequencer; sees only its ports
module dss_sequencer_sva (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        reg_wr_en_in,
  input wire logic        reg_rd_en_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_rdata_valid_out,
  input wire logic        irq_pin_oe_n_out,
  input wire logic        slot_a_pulse_out,
  input wire logic [2:0]  seq_state_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // ********
  // state dwell
  // ********
  logic [2:0]  st_q;
  logic [15:0] dwell;
  // dwell holds how long the state just left was occupied
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= 3'h0;
      dwell <= 16'h0;
    end else begin
      st_q <= seq_state_out;
      dwell <= (seq_state_out != st_q) ? 16'h0 : dwell + 16'h1;
    end
  end
  property p_rd_valid; reg_rd_en_in |=> reg_rdata_valid_out; endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read not answered");
  property p_standby; reg_wr_en_in && reg_addr_in == 8'h10 &&
    reg_wdata_in[1:0] != 2'h2 |-> ##[1:3] seq_state_out == 3'h0; endproperty
  a_standby: assert property (p_standby)
    else $error("no standby");
  property p_irq_buf; reg_wr_en_in && reg_addr_in == 8'h4f |->
    ##2 irq_pin_oe_n_out == $past(reg_wdata_in[1], 2); endproperty
  a_irq_buf: assert property (p_irq_buf)
    else $error("irq buffer wrong");
  property p_pulse_w; $rose(slot_a_pulse_out) |->
    ##19 slot_a_pulse_out ##1 !slot_a_pulse_out; endproperty
  a_pulse_w: assert property (p_pulse_w)
    else $error("pulse width");
  property p_order; $changed(seq_state_out) && $past(seq_state_out) == 3'h3
    |-> seq_state_out inside {3'h4, 3'h6, 3'h0}; endproperty
  a_order: assert property (p_order)
    else $error("slot order");
  property p_comp_a; seq_state_out != st_q && st_q == 3'h3 &&
    seq_state_out != 3'h0 |-> dwell inside {[16'h0532:16'h0564]}; endproperty
  a_comp_a: assert property (p_comp_a)
    else $error("compute a time");
  property p_comp_b; seq_state_out != st_q && st_q == 3'h5 &&
    seq_state_out != 3'h0 |-> dwell inside {[16'h017c:16'h01a4]}; endproperty
  a_comp_b: assert property (p_comp_b)
    else $error("compute b time");
  property p_sleep; seq_state_out != st_q && st_q == 3'h6 &&
    seq_state_out != 3'h0 |-> dwell >= 16'h1140; endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep too short");
endmodule // dss_sequencer_sva

// *** dss_pin_source.sv ***
// far side of the pins: sync edges and an external slow clock
// assumes the bench routes each pin only while the device releases it
module dss_pin_source (
  input  wire logic run_in,
  input  wire logic edge_in,
  output logic      irq_out,
  output logic      pd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // edges come only as the bench paces them
  assign irq_out = edge_in;
  // pd pin sits at a valid low until the clock runs
  initial pd_out = 1'b0;
  always #15259 pd_out = run_in && !pd_out;
endmodule // dss_pin_source

// *** tb_dual_slot_sample_sequencer.sv ***
// self-checking bench of the dual slot sample sequencer
// assumes dss_sequencer, its checker and the pin source compiled first
module tb_dual_slot_sample_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_in, rst_n_in, wr, rd, run, edge_q, rvalid, pa, pb;
  logic        irq_o, irq_oe_n, pd_o, pd_oe_n, aa, lo, hi, irq_s, pd_s, ba;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata;
  logic [2:0]  st;
  logic [1:0]  a_rt, b_rt;
  logic [15:0] shadow [256] = '{default: 16'h0};
  logic [3:0]  codes [4] = '{4'h0, 4'h1, 4'h4, 4'h5};
  logic [7:0]  regs [10] = '{8'h10, 8'h12, 8'h14, 8'h30, 8'h31, 8'h35,
                             8'h36, 8'h38, 8'h4b, 8'h4f};
  int          mismatches, checks_done, seed, n, e, a_len, a_np, b_np;
  // a released pin shows the far side, else the device
  wire irq_w = irq_oe_n ? irq_s : irq_o;
  wire pd_w = pd_oe_n ? pd_s : pd_o;
  dss_sequencer u_dss_sequencer (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .reg_wr_en_in(wr), .reg_rd_en_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rdata_valid_out(rvalid),
    .irq_pin_in(irq_w), .irq_pin_out(irq_o), .irq_pin_oe_n_out(irq_oe_n),
    .pd_pin_in(pd_w), .pd_pin_out(pd_o), .pd_pin_oe_n_out(pd_oe_n),
    .slot_a_pulse_out(pa), .slot_b_pulse_out(pb), .slot_a_active_out(aa),
    .slot_b_active_out(ba), .sensor_lo_connect_out(lo),
    .sensor_hi_connect_out(hi), .seq_state_out(st));
  dss_pin_source u_dss_pin_source (.run_in(run), .edge_in(edge_q),
    .irq_out(irq_s), .pd_out(pd_s));
  // ********
  // model and tasks
  // ********
  function automatic logic [1:0] route(input logic [3:0] c);
    route = {c == 4'h1 || c == 4'h5, c == 4'h1 || c == 4'h4};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys_in);
    {wr, addr, wdata} = {1'b1, a, d};
    if (a inside {regs}) shadow[a] = d;
    @(negedge clk_sys_in);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk_sys_in);
    {rd, addr} = {1'b1, a};
    @(negedge clk_sys_in);
    rd = 1'b0;
    chk({15'h0, rvalid}, 16'h1);
    chk(rdata, shadow[a]);
  endtask
  // bounded wait for a state; n returns the cycles taken
  task automatic wait_st(input logic [2:0] s, input int lim);
    n = 0;
    while (st !== s && n < lim) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk({13'h0, st}, {13'h0, s});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // slot A length, pulse counts and routing seen inside each slot
  always @(posedge clk_sys_in) begin
    if (aa) a_len++;
    if ($rose(pa)) a_np++;
    if ($rose(pb)) b_np++;
    if (st == 3'h2) a_rt = {lo, hi};
    if (st == 3'h4) b_rt = {lo, hi};
  end
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = !clk_sys_in;
  end
  // watchdog: the run takes about 60000 cycles
  initial begin
    repeat (98000) @(posedge clk_sys_in);
    mismatches++;
    end_of_test();
  end
  initial begin
    {rst_n_in, wr, rd, run, edge_q, addr, wdata} = '0;
    seed = 32'hc005;
    shadow[8'h12] = 16'h0008;
    shadow[8'h4b] = 16'h2612;
    repeat (3) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    // reset values, random write and read back, an unmapped place
    foreach (regs[i]) rd_reg(regs[i]);
    for (int i = 1; i < 10; i++) begin
      wr_reg(regs[i], 16'($random(seed)));
      rd_reg(regs[i]);
    end
    wr_reg(8'h20, 16'hffff);
    rd_reg(8'h20);
    wr_reg(8'h38, 16'h0000);
    wr_reg(8'h4f, 16'h0000);
    wr_reg(8'h4b, 16'h2612);
    wr_reg(8'h12, 16'h0010);
    // one period per routing pair; the last leaves slot A unused
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h10, 16'h0001);
      wr_reg(8'h14, {4'h0, codes[3 - i], codes[i], 4'h0});
      wr_reg(8'h30, 16'h0017 + 16'(i));
      wr_reg(8'h31, {8'(i == 3 ? 0 : i + 1), 8'h13 + 8'(i)});
      wr_reg(8'h35, 16'h0018);
      wr_reg(8'h36, 16'h0114);
      {a_len, a_np, b_np, a_rt, b_rt} = '0;
      e = (i == 3) ? 0 : (23 + i + (i + 1) * (19 + i)) * 20;
      wr_reg(8'h10, 16'h0002);
      wait_st(3'h6, 20000);
      chk(16'(a_np), 16'(i == 3 ? 0 : i + 1));
      chk(16'(b_np), 16'h1);
      chk({15'h0, a_len >= e - 20 && a_len <= e + 40}, 16'h1);
      chk({14'h0, a_rt}, {14'h0, i == 3 ? 2'h0 : route(codes[i])});
      chk({14'h0, b_rt}, {14'h0, route(codes[3 - i])});
    end
    wait_st(3'h1, 5000);
    chk({15'h0, n >= 4400}, 16'h1);
    // trigger on the interrupt pin replaces the internal timer
    wr_reg(8'h10, 16'h0001);
    wr_reg(8'h12, 16'h0001);
    wr_reg(8'h4f, 16'h0006);
    wr_reg(8'h38, 16'h4000);
    wr_reg(8'h10, 16'h0002);
    repeat (2000) @(negedge clk_sys_in);
    chk({13'h0, st}, 16'h1);
    edge_q = 1'b1;
    wait_st(3'h4, 2000);
    chk({15'h0, n >= 580 && n <= 1250}, 16'h1);
    // pd pin as slow clock: nothing moves until that clock runs
    edge_q = 1'b0;
    wr_reg(8'h4f, 16'h0020);
    wr_reg(8'h4b, 16'h2792);
    wr_reg(8'h10, 16'h0001);
    wr_reg(8'h38, 16'h0000);
    wr_reg(8'h10, 16'h0002);
    repeat (2000) @(negedge clk_sys_in);
    chk({13'h0, st}, 16'h1);
    run = 1'b1;
    wait_st(3'h4, 3000);
    // leaving normal mode in mid slot stops everything
    wr_reg(8'h10, 16'h0000);
    repeat (3) @(negedge clk_sys_in);
    chk({11'h0, st, ba, pd_o}, 16'h0001);
    run = 1'b0;
    end_of_test();
  end
endmodule // tb_dual_slot_sample_sequencer
bind dss_sequencer dss_sequencer_sva u_sva (.clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in), .reg_wr_en_in(reg_wr_en_in),
  .reg_rd_en_in(reg_rd_en_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_valid_out(reg_rdata_valid_out),
  .irq_pin_oe_n_out(irq_pin_oe_n_out), .slot_a_pulse_out(slot_a_pulse_out),
  .seq_state_out(seq_state_out));
